// >>> verilog/pmt8_pkg.sv
// Purpose: shared constants and types for the period match timer
// Assumes: 32-bit ahb-lite register bus, one word per register
// Notes: register offsets other than control are freely placed
package pmt8_pkg;
   // register word indices (byte address is four times the index)
   localparam logic [11:0] PMT8_OFS_CONTROL = 12'hFCA;
   localparam logic [11:0] PMT8_OFS_COUNT = 12'hFC0;
   localparam logic [11:0] PMT8_OFS_PERIOD = 12'hFC4;
   localparam logic [11:0] PMT8_OFS_STATUS = 12'hFC8;
   localparam logic [11:0] PMT8_OFS_ENABLE = 12'hFCC;
   // the control offset is not word aligned, so offsets are indices
   localparam int PMT8_ADDR_SHIFT = 2;
   localparam int PMT8_ADDR_W = 14;
   // control field positions, and the match flag bit of status and enable
   localparam int PMT8_PRE_LO = 0;
   localparam int PMT8_RUN_BIT = 2;
   localparam int PMT8_POST_LO = 3;
   localparam int PMT8_IRQ_BIT = 1;
   // reset values, and the instruction divider terminal count
   localparam logic [7:0] PMT8_COUNT_RST = 8'h00;
   localparam logic [7:0] PMT8_PERIOD_RST = 8'hFF;
   localparam logic [6:0] PMT8_CONTROL_RST = 7'h00;
   localparam logic [1:0] PMT8_INSTR_DIV_LAST = 2'h3;
   // prescale codes and terminal counts, and ahb-lite htrans and hsize codes
   localparam logic [1:0] PMT8_PRE_DIV1 = 2'h0;
   localparam logic [1:0] PMT8_PRE_DIV4 = 2'h1;
   localparam logic [3:0] PMT8_PRE_LAST1 = 4'h0;
   localparam logic [3:0] PMT8_PRE_LAST4 = 4'h3;
   localparam logic [3:0] PMT8_PRE_LAST16 = 4'hF;
   localparam logic [1:0] PMT8_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] PMT8_HSIZE_WORD = 3'h2;

   // decoded control register contents
   typedef struct packed {
      logic [3:0] postscale_select;
      logic run_bit;
      logic [1:0] prescale_select;
   } pmt8_ctrl_t;

   // latched ahb-lite address phase
   typedef struct packed {
      logic write;
      logic [PMT8_ADDR_W-1:0] index;
   } pmt8_req_t;
endpackage

// >>> verilog/pmt8_timer.sv
// Purpose: 8-bit period match timer with prescaler and postscaler
// Assumes: hclk is the oscillator clock; instruction clock is hclk/4
//    hsize is ignored; every access is one whole word
// Notes: registers on ahb-lite, always okay, zero wait states
//    shift_clock is a one cycle pulse per match, not a square wave
//    count and control writes clear the scalers, never the count
`timescale 1ns/1ps
module pmt8_timer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   output logic shift_clock
);
   // registers and bus state
   pmt8_pkg::pmt8_ctrl_t timer_control;
   pmt8_pkg::pmt8_req_t req;
   logic req_valid;
   logic [7:0] count_value;
   logic [7:0] period_value;
   logic [7:0] enable_reg;
   logic [7:0] status_reg;
   // timer datapath
   logic [1:0] instr_div;
   logic [3:0] pre_cnt;
   logic [3:0] post_cnt;
   logic [3:0] pre_last;
   logic instr_tick;
   logic timer_tick;
   logic match;
   logic post_done;
   // write strobes of the data phase
   logic wr_control;
   logic wr_count;
   logic wr_period;
   logic wr_status;
   logic wr_enable;
   logic next_flag;

   // register map, one word each, index = haddr[15:2]
   //   control: [1:0] prescale, [2] run, [6:3] postscale, [7] reads 0
   //   count: live timer count, software may overwrite it at any time
   //   period: match value, all ones out of reset
   //   status: [1] sticky match flag, write one to clear
   //   enable: [1] match interrupt enable
   // everything else reads zero and ignores writes
   localparam int PMT8_ADDR_W_L = pmt8_pkg::PMT8_ADDR_W;
   localparam logic [PMT8_ADDR_W_L-1:0] IDX_CONTROL =
      PMT8_ADDR_W_L'(pmt8_pkg::PMT8_OFS_CONTROL);
   localparam logic [PMT8_ADDR_W_L-1:0] IDX_COUNT =
      PMT8_ADDR_W_L'(pmt8_pkg::PMT8_OFS_COUNT);
   localparam logic [PMT8_ADDR_W_L-1:0] IDX_PERIOD =
      PMT8_ADDR_W_L'(pmt8_pkg::PMT8_OFS_PERIOD);
   localparam logic [PMT8_ADDR_W_L-1:0] IDX_STATUS =
      PMT8_ADDR_W_L'(pmt8_pkg::PMT8_OFS_STATUS);
   localparam logic [PMT8_ADDR_W_L-1:0] IDX_ENABLE =
      PMT8_ADDR_W_L'(pmt8_pkg::PMT8_OFS_ENABLE);
   // index of the transfer now in its data phase
   logic [PMT8_ADDR_W_L-1:0] cur_index;

   // address phase capture, zero wait states
   // only a phase that the bus accepts (hready high) is taken, so a
   // transfer stalled elsewhere on the bus never lands here twice
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_valid <= 1'b0;
         req <= '0;
      end else if (hready) begin
         req_valid <= hsel && (htrans == pmt8_pkg::PMT8_HTRANS_NONSEQ);
         req.write <= hwrite;
         req.index <= haddr[pmt8_pkg::PMT8_ADDR_SHIFT +: PMT8_ADDR_W_L];
      end
   end

   // data phase write strobes
   // a write lands at the end of its data phase, while hwdata stands
   always_comb begin
      cur_index = req.index;
      wr_control = req_valid && req.write && (cur_index == IDX_CONTROL);
      wr_count = req_valid && req.write && (cur_index == IDX_COUNT);
      wr_period = req_valid && req.write && (cur_index == IDX_PERIOD);
      wr_status = req_valid && req.write && (cur_index == IDX_STATUS);
      wr_enable = req_valid && req.write && (cur_index == IDX_ENABLE);
   end

   // read mux, registered into hrdata for the next data phase
   // sampling at the address phase lets hrdata come from a flop and
   // still stand for the whole data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (hready && hsel && !hwrite &&
                   htrans == pmt8_pkg::PMT8_HTRANS_NONSEQ) begin
         if (haddr[pmt8_pkg::PMT8_ADDR_SHIFT +: PMT8_ADDR_W_L]
             == IDX_CONTROL) begin
            hrdata <= {25'h0, timer_control};
         end else if (haddr[pmt8_pkg::PMT8_ADDR_SHIFT +: PMT8_ADDR_W_L]
                      == IDX_COUNT) begin
            hrdata <= {24'h000000, count_value};
         end else if (haddr[pmt8_pkg::PMT8_ADDR_SHIFT +: PMT8_ADDR_W_L]
                      == IDX_PERIOD) begin
            hrdata <= {24'h000000, period_value};
         end else if (haddr[pmt8_pkg::PMT8_ADDR_SHIFT +: PMT8_ADDR_W_L]
                      == IDX_STATUS) begin
            hrdata <= {24'h000000, status_reg};
         end else if (haddr[pmt8_pkg::PMT8_ADDR_SHIFT +: PMT8_ADDR_W_L]
                      == IDX_ENABLE) begin
            hrdata <= {24'h000000, enable_reg};
         end else begin
            hrdata <= '0; // unmapped reads zero
         end
      end
   end

   // bus handshake outputs never stall and never error
   // hreadyout is low in reset so no master starts a transfer early
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // control register, bit seven not stored
   // bit seven is never kept, so it always reads back zero
   // a write here also clears both scalers, see below
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_control <= pmt8_pkg::PMT8_CONTROL_RST;
      end else if (wr_control) begin
         timer_control <= hwdata[6:0];
      end
   end

   // period register
   // a new period is used by the very next compare
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_value <= pmt8_pkg::PMT8_PERIOD_RST;
      end else if (wr_period) begin
         period_value <= hwdata[7:0];
      end
   end

   // instruction clock divider, oscillator over four
   // free running: register writes do not restart it, so the first
   // tick after a write comes zero to three cycles later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr_div <= '0;
      end else begin
         instr_div <= instr_div + 2'h1;
      end
   end

   // prescale terminal count selection
   // terminal compares use >= so a count left above a new, smaller
   // terminal wraps at once instead of running round
   always_comb begin
      instr_tick = (instr_div == pmt8_pkg::PMT8_INSTR_DIV_LAST);
      if (timer_control.prescale_select == pmt8_pkg::PMT8_PRE_DIV1) begin
         pre_last = pmt8_pkg::PMT8_PRE_LAST1;
      end else if (timer_control.prescale_select ==
                   pmt8_pkg::PMT8_PRE_DIV4) begin
         pre_last = pmt8_pkg::PMT8_PRE_LAST4;
      end else begin
         pre_last = pmt8_pkg::PMT8_PRE_LAST16;
      end
      timer_tick = timer_control.run_bit && instr_tick &&
                   (pre_cnt >= pre_last);
      match = (count_value == period_value);
      post_done = (post_cnt >= timer_control.postscale_select);
   end

   // 4-bit prescale counter
   // cleared on count and control writes so a new setting starts clean
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt <= '0;
      end else if (wr_count || wr_control) begin
         pre_cnt <= '0;
      end else if (timer_control.run_bit && instr_tick) begin
         pre_cnt <= (pre_cnt >= pre_last) ? 4'h0 : pre_cnt + 4'h1;
      end
   end

   // count register: software write, clear after match, increment
   // a software write beats a tick in the same cycle; a period below
   // the present count lets the count run through 255 and wrap to zero
   // before the next match
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_value <= pmt8_pkg::PMT8_COUNT_RST;
      end else if (wr_count) begin
         count_value <= hwdata[7:0];
      end else if (timer_tick) begin
         if (match) begin
            count_value <= pmt8_pkg::PMT8_COUNT_RST;
         end else begin
            count_value <= count_value + 8'h01;
         end
      end
      // control writes leave the count alone
   end

   // postscale counter clocked by matches
   // runs 0 to code, so code N gives one completion in N+1 matches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         post_cnt <= '0;
      end else if (wr_count || wr_control) begin
         post_cnt <= '0;
      end else if (timer_tick && match) begin
         post_cnt <= post_done ? 4'h0 : post_cnt + 4'h1;
      end
   end

   // shift clock pulse for the serial port, one per match
   // one hclk wide; a serial port on another clock must stretch or
   // synchronise it before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_clock <= 1'b0;
      end else begin
         shift_clock <= timer_tick && match;
      end
   end

   // sticky match flag, set wins over write-one-to-clear
   // a clear and a completion in one cycle leave the flag set, so no
   // match interrupt is ever lost to a late clear
   always_comb begin
      next_flag = status_reg[pmt8_pkg::PMT8_IRQ_BIT];
      if (wr_status && hwdata[pmt8_pkg::PMT8_IRQ_BIT]) begin
         next_flag = 1'b0;
      end
      if (timer_tick && match && post_done) begin
         next_flag = 1'b1;
      end
   end

   // status register, only the match flag bit is stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= '0;
      end else begin
         status_reg <= '0;
         status_reg[pmt8_pkg::PMT8_IRQ_BIT] <= next_flag;
      end
   end

   // interrupt enable register, only the match bit is kept
   // the other bits read back zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_reg <= '0;
      end else if (wr_enable) begin
         enable_reg <= '0;
         enable_reg[pmt8_pkg::PMT8_IRQ_BIT] <=
            hwdata[pmt8_pkg::PMT8_IRQ_BIT];
      end
   end

   // level interrupt from flag and enable
   // built from next_flag so irq rises on the same edge as the flag
   // and falls on the same edge as a clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_flag && enable_reg[pmt8_pkg::PMT8_IRQ_BIT];
      end
   end
endmodule

// >>> sim/pmt8_props.sv
// Purpose: port properties of the period match timer
// Assumes: zero wait state slave, one clock
// Notes: bound to pmt8_timer
`timescale 1ns/1ps
module pmt8_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic irq,
   input wire logic shift_clock
);
   logic ap, rd, wr;
   // accepted address phases
   assign ap = hsel && hready && htrans == 2'h2;
   assign rd = ap && !hwrite;
   assign wr = ap && hwrite;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   resp_okay_a: assert property (!hresp)
      else $error("response not okay");
   no_wait_a: assert property ($past(hresetn) |-> hreadyout)
      else $error("wait state seen");
   rdata_hold_a: assert property (!rd |=> $stable(hrdata))
      else $error("read data moved");
   upper_zero_a: assert property (rd |=> hrdata[31:8] == 24'h0)
      else $error("upper read bits set");
   ctl_bit7_a: assert property (
      rd && haddr == 32'h3F28 |=> !hrdata[7])
      else $error("control bit 7 read as one");
   tick_gap_a: assert property (shift_clock |=> !shift_clock [*3])
      else $error("match pulses too close");
   irq_fall_a: assert property ($fell(irq) |->
      $past(wr, 2) || $past(wr, 3))
      else $error("irq fell without write");
   irq_rise_a: assert property ($rose(irq) |-> shift_clock ||
      $past(shift_clock) || $past(shift_clock, 2) || $past(wr, 2) ||
      $past(wr, 3)) else $error("irq rose without match");
   // main scenarios
   irq_c: cover property ($rose(irq));
   pulse_c: cover property (shift_clock);
   read_c: cover property (rd);
endmodule
bind pmt8_timer pmt8_props pmt8_props_i (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .irq,
   .shift_clock);

// >>> sim/testbench.sv
// Purpose: self-checking bench for the period match timer
// Assumes: zero wait state bus
// Notes: rows check match pulse spacing per prescale code
`timescale 1ns/1ps
module testbench;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic hreadyout, hresp, irq, shift_clock;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   int fails, tests_run, cyc, since, gap, pulses, base;
   // register byte addresses
   localparam logic [31:0] CTL = 32'h3F28;
   localparam logic [31:0] CNT = 32'h3F00;
   localparam logic [31:0] PER = 32'h3F10;
   localparam logic [31:0] STS = 32'h3F20;
   localparam logic [31:0] ENA = 32'h3F30;
   // rows: prescale code, period, expected pulse gap
   logic [1:0] r_pre [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic [7:0] r_per [4] = '{8'h02, 8'h01, 8'h00, 8'h03};
   int r_gap [4] = '{12, 32, 64, 256};
   pmt8_timer pmt8_timer_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .irq, .shift_clock);
   // 50 mhz clock
   initial forever #10 hclk = ~hclk;
   // one single transfer, read data kept in rd
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // read and compare
   task automatic rdc(input logic [31:0] a, e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // verdict
   task automatic close_out;
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // match pulse spacing and count, taken at falling edges
   always @(negedge hclk) begin
      since <= shift_clock ? 0 : since + 1;
      if (shift_clock) gap <= since + 1;
      if (shift_clock) pulses <= pulses + 1;
   end
   // hang guard
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      // table rows
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, PER, {24'h0, r_per[i]});
         bus(1'b1, CNT, 32'h0);
         bus(1'b1, CTL, {29'h0, 1'b1, r_pre[i]});
         repeat (3) @(posedge shift_clock);
         @(posedge hclk);
         chk("pulse gap", r_gap[i], gap);
         $display("row %0d done", i);
      end
      // registers with the timer stopped
      bus(1'b1, CTL, 32'h0);
      bus(1'b1, CNT, 32'h37);
      bus(1'b1, PER, 32'h5A);
      bus(1'b1, CTL, 32'hFB);
      repeat (50) @(posedge hclk);
      rdc(CTL, 32'h7B, "control");
      rdc(CNT, 32'h37, "count");
      rdc(PER, 32'h5A, "period");
      rdc(32'h100, 32'h0, "unmapped");
      chk("response", 32'h0, hresp);
      $display("register test done");
      // interrupt after three matches, postscaler first left part way
      bus(1'b1, PER, 32'h0);
      bus(1'b1, CNT, 32'h0);
      bus(1'b1, CTL, 32'h7C);
      repeat (20) @(posedge hclk);
      bus(1'b1, CTL, 32'h0);
      bus(1'b1, STS, 32'h2);
      bus(1'b1, ENA, 32'h2);
      base = pulses;
      bus(1'b1, CTL, 32'h14);
      wait (irq === 1'b1);
      @(posedge hclk);
      chk("matches", 32'h3, pulses - base);
      bus(1'b1, ENA, 32'h0);
      repeat (2) @(negedge hclk);
      chk("irq masked", 32'h0, irq);
      rdc(STS, 32'h2, "flag held");
      bus(1'b1, CTL, 32'h0);
      bus(1'b1, STS, 32'h2);
      bus(1'b1, ENA, 32'h2);
      rdc(STS, 32'h0, "flag cleared");
      chk("irq cleared", 32'h0, irq);
      $display("interrupt test done");
      // reset in mid-run
      bus(1'b1, CNT, 32'h20);
      bus(1'b1, CTL, 32'h04);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(CNT, 32'h0, "count reset");
      rdc(PER, 32'hFF, "period reset");
      rdc(CTL, 32'h0, "control reset");
      $display("reset test done");
      close_out();
   end
endmodule
